// ==== logic/sfam_pkg.sv ====
// What this block does
// - Commands can carry a full 32-bit byte address reaching up to 4 GB.
// - Legacy commands still accept three address bytes unchanged.
// - A legacy 24-bit address takes its high byte from the bank register.
// - With extended mode set, legacy commands take four address bytes.
// - The newer command variants always take four address bytes.
// - Reset clears the bank register and selects 24-bit mode.
// - With defaults, 24-bit commands reach only the lowest 16 MB.
// - Opcode 5Ah uses the full 32-bit address format; opcode 9Fh takes no address bytes.
// - The array is 256 sectors of 256 KB, the first at 00000000h-0003FFFFh.
// - Opcode 9Fh reads the identification space, not the array.
// - The identification space is read-only; writes have no effect.
// - Opcode 5Ah reads the discoverable-parameters space.
// - The parameters space holds the identification data as one table.
// - The parameters space is read-only; program and erase have no effect.
package sfam_pkg;
	localparam logic [7:0] SFAM_OP_READ = 8'h03;
	localparam logic [7:0] SFAM_OP_READ4 = 8'h13;
	localparam logic [7:0] SFAM_OP_PP = 8'h02;
	localparam logic [7:0] SFAM_OP_PP4 = 8'h12;
	localparam logic [7:0] SFAM_OP_SE = 8'hD8;
	localparam logic [7:0] SFAM_OP_SE4 = 8'hDC;
	localparam logic [7:0] SFAM_OP_BANK_WR = 8'h17;
	localparam logic [7:0] SFAM_OP_RDID = 8'h9F;
	localparam logic [7:0] SFAM_OP_RDPARAM = 8'h5A;
	localparam logic [7:0] SFAM_BANK_RESET = 8'h00;
	localparam int SFAM_EXTADD_BIT = 7;
	localparam int SFAM_BANK_HI_BIT = 6;
	localparam int SFAM_SECTOR_LSB = 18;
	localparam int SFAM_SECTOR_W = 8;
	localparam logic [31:0] SFAM_ARRAY_LIMIT = 32'h0400_0000;
	localparam logic [2:0] SFAM_BYTES3 = 3'h3;
	localparam logic [2:0] SFAM_BYTES4 = 3'h4;
	localparam logic [2:0] SFAM_BYTES1 = 3'h1;
	localparam logic [2:0] SFAM_BYTES0 = 3'h0;
	typedef enum logic [1:0] {SFAM_SP_ARRAY, SFAM_SP_ID, SFAM_SP_PARAM, SFAM_SP_NONE} sfam_space_e;
	typedef enum logic [1:0] {SFAM_ACC_READ, SFAM_ACC_PROG, SFAM_ACC_ERASE, SFAM_ACC_REG} sfam_acc_e;
endpackage : sfam_pkg

// ==== logic/sfam_map.sv ====
`timescale 1ns/1ns
module sfam_map
	import sfam_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_byte_vld,
	input wire logic [7:0] i_byte,
	output logic o_addr_vld,
	output logic [31:0] o_addr,
	output logic [1:0] o_space,
	output logic [1:0] o_access,
	output logic o_write_en,
	output logic [SFAM_SECTOR_W-1:0] o_sector,
	output logic [7:0] o_bank
);
	typedef enum logic [1:0] {SFAM_ST_OPC, SFAM_ST_ADDR, SFAM_ST_DATA} sfam_st_e;
	typedef struct packed {
		sfam_st_e st;
		logic [7:0] opc;
		logic [2:0] need;
		logic [2:0] cnt;
		logic [31:0] addr;
		logic [7:0] bank;
		logic cs_m;
		logic cs_s;
		logic vld_m;
		logic vld_s;
		logic [7:0] byte_m;
		logic [7:0] byte_s;
		logic addr_vld;
		logic [1:0] space;
		logic [1:0] access;
		logic write_en;
		logic [SFAM_SECTOR_W-1:0] sector;
	} sfam_state_s;
	sfam_state_s st_reg;
	sfam_state_s st_next;
	logic byte_take;
	logic [2:0] need_bytes;
	logic last_byte;
	logic [31:0] full_addr;

	function automatic logic [2:0] sfam_addr_bytes(input logic [7:0] op, input logic ext);
		logic [2:0] n;
		n = SFAM_BYTES0;
		case (op)
			SFAM_OP_READ, SFAM_OP_PP, SFAM_OP_SE:
				n = ext ? SFAM_BYTES4 : SFAM_BYTES3;
			SFAM_OP_READ4, SFAM_OP_PP4, SFAM_OP_SE4:
				n = SFAM_BYTES4;
			SFAM_OP_RDPARAM:
				n = SFAM_BYTES4;
			SFAM_OP_BANK_WR:
				n = SFAM_BYTES1;
			default:
				n = SFAM_BYTES0;
		endcase
		return n;
	endfunction : sfam_addr_bytes

	function automatic logic [1:0] sfam_acc(input logic [7:0] op);
		logic [1:0] a;
		a = SFAM_ACC_READ;
		if (op == SFAM_OP_PP || op == SFAM_OP_PP4)
			a = SFAM_ACC_PROG;
		else if (op == SFAM_OP_SE || op == SFAM_OP_SE4)
			a = SFAM_ACC_ERASE;
		else if (op == SFAM_OP_BANK_WR)
			a = SFAM_ACC_REG;
		return a;
	endfunction : sfam_acc

	assign byte_take = st_reg.vld_s && !st_reg.cs_s;
	assign need_bytes = sfam_addr_bytes(st_reg.byte_s, st_reg.bank[SFAM_EXTADD_BIT]);
	assign last_byte = (st_reg.cnt + 3'h1) == st_reg.need;
	assign full_addr = (st_reg.need == SFAM_BYTES3)
		? {st_reg.bank, st_reg.addr[15:0], st_reg.byte_s}
		: {st_reg.addr[23:0], st_reg.byte_s};

	always_comb
	begin
		st_next = st_reg;
		st_next.cs_m = i_cs_n;
		st_next.cs_s = st_reg.cs_m;
		st_next.vld_m = i_byte_vld;
		st_next.vld_s = st_reg.vld_m;
		st_next.byte_m = i_byte;
		st_next.byte_s = st_reg.byte_m;
		st_next.addr_vld = 1'b0;
		if (st_reg.cs_s)
			st_next.st = SFAM_ST_OPC;
		else if (byte_take)
		begin
			case (st_reg.st)
				SFAM_ST_OPC:
				begin
					st_next.opc = st_reg.byte_s;
					st_next.need = need_bytes;
					st_next.cnt = 3'h0;
					st_next.addr = 32'h0;
					if (st_reg.byte_s == SFAM_OP_RDID)
					begin
						st_next.addr_vld = 1'b1;
						st_next.addr = 32'h0;
						// Sector follows the zero address so it never shows a stale index
						st_next.sector = '0;
						st_next.space = SFAM_SP_ID;
						st_next.access = SFAM_ACC_READ;
						st_next.write_en = 1'b0;
						st_next.st = SFAM_ST_DATA;
					end
					else if (need_bytes == SFAM_BYTES0)
						st_next.st = SFAM_ST_DATA;
					else
						st_next.st = SFAM_ST_ADDR;
				end
				SFAM_ST_ADDR:
				begin
					st_next.cnt = st_reg.cnt + 3'h1;
					st_next.addr = {st_reg.addr[23:0], st_reg.byte_s};
					if (last_byte)
					begin
						st_next.st = SFAM_ST_DATA;
						st_next.access = sfam_acc(st_reg.opc);
						if (st_reg.opc == SFAM_OP_BANK_WR)
						begin
							st_next.bank = st_reg.byte_s;
							st_next.write_en = 1'b0;
						end
						else
						begin
							st_next.addr = full_addr;
							st_next.addr_vld = 1'b1;
							st_next.sector = full_addr[SFAM_SECTOR_LSB +: SFAM_SECTOR_W];
							if (st_reg.opc == SFAM_OP_RDPARAM)
							begin
								st_next.space = SFAM_SP_PARAM;
								st_next.write_en = 1'b0;
							end
							else if (full_addr < SFAM_ARRAY_LIMIT)
							begin
								st_next.space = SFAM_SP_ARRAY;
								st_next.write_en = sfam_acc(st_reg.opc) != SFAM_ACC_READ;
							end
							else
							begin
								st_next.space = SFAM_SP_NONE;
								st_next.write_en = 1'b0;
							end
						end
					end
				end
				default:
					st_next.st = SFAM_ST_DATA;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_reg <= '0;
			st_reg.st <= SFAM_ST_OPC;
			st_reg.bank <= SFAM_BANK_RESET;
			st_reg.cs_m <= 1'b1;
			st_reg.cs_s <= 1'b1;
			st_reg.space <= SFAM_SP_ARRAY;
		end
		else
			st_reg <= st_next;
	end

	assign o_addr_vld = st_reg.addr_vld;
	assign o_addr = st_reg.addr;
	assign o_space = st_reg.space;
	assign o_access = st_reg.access;
	assign o_write_en = st_reg.write_en;
	assign o_sector = st_reg.sector;
	assign o_bank = st_reg.bank;

	a_default_reach: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_reg.bank == SFAM_BANK_RESET && st_reg.need == SFAM_BYTES3 && o_addr_vld)
		|-> o_addr[31:24] == 8'h00) else $error("24-bit access left lowest 16 MB");
	a_bank_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_addr_vld && st_reg.need == SFAM_BYTES3 && o_space != SFAM_SP_ID)
		|-> o_addr[31:24] == o_bank) else $error("bank byte not applied");
	a_ext_four: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_reg.st == SFAM_ST_ADDR && st_reg.bank[SFAM_EXTADD_BIT]
		&& st_reg.opc == SFAM_OP_READ) |-> st_reg.need == SFAM_BYTES4)
		else $error("extended mode not four bytes");
	a_new_four: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(st_reg.st == SFAM_ST_ADDR && (st_reg.opc == SFAM_OP_READ4
		|| st_reg.opc == SFAM_OP_SE4)) |-> st_reg.need == SFAM_BYTES4)
		else $error("new command not four bytes");
	a_id_ro: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_space == SFAM_SP_ID || o_space == SFAM_SP_PARAM) |-> !o_write_en)
		else $error("read-only space writable");
	a_param_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_addr_vld && st_reg.opc == SFAM_OP_RDPARAM) |-> o_space == SFAM_SP_PARAM)
		else $error("parameter read misrouted");
	a_sector_idx: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_addr_vld |-> o_sector == o_addr[SFAM_SECTOR_LSB +: SFAM_SECTOR_W])
		else $error("sector index wrong");
	a_id_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(byte_take && st_reg.st == SFAM_ST_OPC && st_reg.byte_s == SFAM_OP_RDID)
		|=> (o_addr_vld && o_space == SFAM_SP_ID)) else $error("ID read misrouted");
endmodule : sfam_map

// ==== dv/sfam_host.sv ====
`timescale 1ns/1ns
module sfam_host
(
	input wire logic i_clk,
	output logic o_cs_n,
	output logic o_byte_vld,
	output logic [7:0] o_byte
);
	initial
	begin
		o_cs_n = 1'b1;
		o_byte_vld = 1'b0;
		o_byte = 8'hA5;
	end
	// Opcode, then n address bytes; gap stretches the byte hold
	task automatic frame(input logic [7:0] op, input int n, input logic [31:0] a, input int gap);
		logic [7:0] b;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		for (int i = -1; i < n; i++)
		begin
			if (i < 0)
				b = op;
			else
				b = a[8*(n-1-i) +: 8];
			// Byte settles a cycle before its strobe
			@(posedge i_clk);
			o_byte <= b;
			@(posedge i_clk);
			o_byte_vld <= 1'b1;
			@(posedge i_clk);
			o_byte_vld <= 1'b0;
			repeat (3 + gap) @(posedge i_clk);
		end
		o_cs_n <= 1'b1;
		o_byte <= ~b;
		repeat (4) @(posedge i_clk);
	endtask : frame
endmodule : sfam_host

// ==== dv/test_sfam_map.sv ====
`timescale 1ns/1ns
module test_sfam_map
	import sfam_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_cs_n;
	logic i_byte_vld;
	logic [7:0] i_byte;
	logic o_addr_vld;
	logic o_write_en;
	logic [31:0] o_addr;
	logic [1:0] o_space;
	logic [1:0] o_access;
	logic [7:0] o_sector;
	logic [7:0] o_bank;
	logic got;
	int mismatches = 0;
	int checks_done = 0;
	always #2 i_clk = ~i_clk;
	sfam_map i_sfam_map (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
		.i_byte_vld(i_byte_vld), .i_byte(i_byte), .o_addr_vld(o_addr_vld), .o_addr(o_addr),
		.o_space(o_space), .o_access(o_access), .o_write_en(o_write_en),
		.o_sector(o_sector), .o_bank(o_bank));
	sfam_host i_sfam_host (.i_clk(i_clk), .o_cs_n(i_cs_n), .o_byte_vld(i_byte_vld),
		.o_byte(i_byte));
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic do_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
	endtask : do_reset
	// Runs one frame and watches for the formed-address pulse
	task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] a, input int gap);
		got = 1'b0;
		fork
			i_sfam_host.frame(op, n, a, gap);
			for (int k = 0; k < 60; k++)
			begin
				@(negedge i_clk);
				if (o_addr_vld === 1'b1)
					got = 1'b1;
			end
		join
	endtask : cmd
	task automatic form(input logic [7:0] op, input int n, input logic [31:0] a, input int gap,
		input logic [31:0] ea, input logic [1:0] es, input logic [1:0] eacc, input logic ewe);
		cmd(op, n, a, gap);
		chk(got, 32'h1);
		if (got !== 1'b1)
			summarize();
		chk(o_addr, ea);
		chk(o_space, es);
		chk(o_access, eacc);
		chk(o_write_en, ewe);
		chk(o_sector, ea[SFAM_SECTOR_LSB +: SFAM_SECTOR_W]);
	endtask : form
	task automatic t_legacy();
		form(SFAM_OP_READ, 3, 32'h12_3456, 0, 32'h0012_3456, 2'h0, 2'h0, 1'b0);
		form(SFAM_OP_SE, 3, 32'h03_FFFF, 0, 32'h0003_FFFF, 2'h0, 2'h2, 1'b1);
		form(SFAM_OP_PP, 3, 32'h04_0000, 4, 32'h0004_0000, 2'h0, 2'h1, 1'b1);
	endtask : t_legacy
	task automatic t_bank();
		cmd(SFAM_OP_BANK_WR, 1, 32'h01, 0);
		chk(got, 32'h0);
		chk(o_bank, 32'h01);
		chk(o_access, 32'h3);
		form(SFAM_OP_READ, 3, 32'h00_0010, 0, 32'h0100_0010, 2'h0, 2'h0, 1'b0);
		form(SFAM_OP_SE4, 4, 32'h0000_0000, 0, 32'h0000_0000, 2'h0, 2'h2, 1'b1);
		form(SFAM_OP_READ4, 4, 32'h03FC_0000, 0, 32'h03FC_0000, 2'h0, 2'h0, 1'b0);
		form(SFAM_OP_PP4, 4, 32'h0500_0000, 0, 32'h0500_0000, 2'h3, 2'h1, 1'b0);
	endtask : t_bank
	task automatic t_ext();
		cmd(SFAM_OP_BANK_WR, 1, 32'h80, 0);
		chk(o_bank, 32'h80);
		form(SFAM_OP_READ, 4, 32'h0234_5678, 0, 32'h0234_5678, 2'h0, 2'h0, 1'b0);
		cmd(SFAM_OP_READ, 3, 32'h11_2233, 0);
		chk(got, 32'h0);
	endtask : t_ext
	task automatic t_spaces();
		cmd(SFAM_OP_RDID, 0, 32'h0, 0);
		chk(got, 32'h1);
		chk(o_space, 32'h1);
		chk(o_write_en, 32'h0);
		form(SFAM_OP_RDPARAM, 4, 32'h10, 0, 32'h10, 2'h2, 2'h0, 1'b0);
	endtask : t_spaces
	initial
	begin
		do_reset();
		chk(o_bank, SFAM_BANK_RESET);
		t_legacy();
		t_bank();
		t_ext();
		t_spaces();
		do_reset();
		chk(o_bank, SFAM_BANK_RESET);
		form(SFAM_OP_READ, 3, 32'h12_3456, 0, 32'h0012_3456, 2'h0, 2'h0, 1'b0);
		summarize();
	end
endmodule : test_sfam_map
